// ---- hdl/ssm_pkg.sv ----
// constants, register map and carrier types of the standstill monitor
package ssm_pkg;
  localparam int CLK_HZ       = 20_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int INTERVAL_MS  = 4;
  localparam int INTERVAL_CYC = INTERVAL_MS * CYC_PER_MS;
  localparam int TLIM_S_DEF   = 1;
  localparam int STUCK_EDGES  = 4;
  localparam logic [6:0] PCT_FULL = 7'd100;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_IVAL  = 8'h04;
  localparam logic [7:0] A_SLIM  = 8'h08;
  localparam logic [7:0] A_PLO   = 8'h0c;
  localparam logic [7:0] A_PHI   = 8'h10;
  localparam logic [7:0] A_PREF  = 8'h14;
  localparam logic [7:0] A_HYST  = 8'h18;
  localparam logic [7:0] A_TLIM  = 8'h1c;
  localparam logic [7:0] A_TOL   = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_POS   = 8'h28;
  localparam logic [7:0] A_SPD   = 8'h2c;
  localparam logic [7:0] A_ISTAT = 8'h30;
  localparam logic [7:0] A_IMASK = 8'h34;
  localparam logic [7:0] A_ERREN = 8'h38;

  localparam int C_MODE = 0;
  localparam int C_TWO  = 2;
  localparam int C_MAN  = 3;
  localparam int C_REF  = 4;
  localparam int C_MUTE = 5;
  localparam int C_BYP  = 6;
  localparam int C_TLIM = 7;
  localparam int C_DIR  = 8;
  localparam int C_CMP  = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0082;

  localparam logic [1:0] MODE_POS = 2'h1;

  localparam int E_GEN    = 0;
  localparam int E_CUTOFF = 1;
  localparam int E_STUCK  = 2;
  localparam int E_PHASE  = 3;
  localparam int E_DISC   = 4;
  localparam int E_SLIM   = 5;
  localparam int E_SDIFF  = 6;
  localparam int E_PRNG   = 7;
  localparam int E_PDIFF  = 8;
  localparam int N_ERR    = 9;
  localparam int I_REL    = 9;
  localparam int N_IRQ    = 10;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ssm_apb_req_t;

  typedef struct packed {
    logic a;
    logic b;
  } ssm_quad_t;

  typedef struct packed {
    logic refer;
    logic restart;
    logic reset;
    logic mute;
    logic bypass;
  } ssm_ctl_t;

  typedef enum logic [1:0] {SSM_IDLE, SSM_WAIT_ACK, SSM_GRANT, SSM_FAULT} ssm_state_t;
endpackage

// ---- hdl/ssm_standstill_monitor.sv ----
// standstill monitor: quadrature decode, speed/position check, release control, apb registers
// Notes on behaviour
// - mode 1 checks position, 2 speed, 3 both; 2 after reset
// - one or two motion inputs, default one; second only if fitted
// - falling edge on reference input loads start value into position
// - manual mode needs restart low-high-low before release; automatic does not
// - mute input high keeps an existing release after monitoring drops it
// - error drops release unless mute keeps or bypass forces it, raises reset-required; reset pulse resumes once cause gone
// - restart-required is high while a release awaits acknowledgement
// - release high only when all configured conditions hold, when mute keeps an existing release, or when bypass forces it
// - release derived from position, speed or both per mode
// - with time limit on, mute and bypass end after 0 s to 8191 s (13-bit seconds field)
// - direction off: only non-negative speed below limit; on: symmetric limit
// - reference, mute and bypass inputs each enabled separately, default off
// - nine error outputs, each enabled separately
// - standstill means speed below limit and/or position inside window
// - hysteresis narrows limits by a percentage when switching release on
// - two-input deviation beyond tolerance drops release after tolerance time
`timescale 1ns/1ns
module ssm_standstill_monitor import ssm_pkg::*; #(
  parameter int CYC_MS   = CYC_PER_MS,
  parameter int IVAL_DEF = INTERVAL_CYC,
  parameter bit HAS_S2   = 1'b1,
  parameter int STUCK_N  = STUCK_EDGES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire ssm_apb_req_t     apb_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire ssm_quad_t [1:0]  sens_i,
  input  wire ssm_ctl_t         ctl_i,
  output logic                  release_o,
  output logic                  restart_req_o,
  output logic                  reset_req_o,
  output logic [N_ERR-1:0]      err_o,
  output logic                  irq_o
);
  logic [31:0] ctrl_ff, ival_ff, slim_ff, plo_ff, phi_ff, pref_ff, hyst_ff, tlim_ff, tol_ff;
  logic [31:0] nxt_ctrl, nxt_ival, nxt_slim, nxt_plo, nxt_phi, nxt_pref, nxt_hyst, nxt_tlim, nxt_tol;
  logic [31:0] imask_ff, erren_ff, prdata_ff, nxt_imask, nxt_erren, nxt_prdata;
  logic [N_IRQ-1:0] istat_ff, nxt_istat, irq_ev;
  logic        wr, mapped;

  function automatic logic [31:0] hyst_amt(input logic [31:0] v, input logic [5:0] p);
    logic [37:0] m;
    m = {6'h0, v} * {32'h0, p};
    return 32'(m / 38'(PCT_FULL));
  endfunction

  function automatic logic [31:0] absv(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  ssm_state_t        st_ff, nxt_st;
  logic              rel_ff, nxt_rel;
  logic [N_ERR-1:0]  err_ff, nxt_err, live;
  logic signed [31:0] cnt_ff [2], pos_ff [2], spd_ff [2];
  logic [1:0]        ph_ev, co_ev, st_ev;

  // control fields
  logic [1:0] mode;
  logic       two, manual, ref_en, mute_en, byp_en, tlim_on, dir_on, cmp_on, pos_chk, spd_chk;
  assign mode    = ctrl_ff[C_MODE +: 2];
  assign two     = ctrl_ff[C_TWO] & HAS_S2;
  assign manual  = ctrl_ff[C_MAN];
  assign ref_en  = ctrl_ff[C_REF];
  assign mute_en = ctrl_ff[C_MUTE];
  assign byp_en  = ctrl_ff[C_BYP];
  assign tlim_on = ctrl_ff[C_TLIM];
  assign dir_on  = ctrl_ff[C_DIR];
  assign cmp_on  = ctrl_ff[C_CMP] & two;
  assign pos_chk = mode[0];
  assign spd_chk = (mode != MODE_POS);

  // apb slave: zero wait states, read data captured in the setup cycle
  assign wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  always_comb begin
    case (apb_i.paddr)
      A_CTRL, A_IVAL, A_SLIM, A_PLO, A_PHI, A_PREF, A_HYST, A_TLIM, A_TOL,
      A_STAT, A_POS, A_SPD, A_ISTAT, A_IMASK, A_ERREN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_i.psel & apb_i.penable & ~mapped;
  assign prdata_o  = prdata_ff;

  always_comb begin
    nxt_ctrl = ctrl_ff; nxt_ival = ival_ff; nxt_slim = slim_ff; nxt_plo = plo_ff;
    nxt_phi = phi_ff; nxt_pref = pref_ff; nxt_hyst = hyst_ff; nxt_tlim = tlim_ff;
    nxt_tol = tol_ff; nxt_imask = imask_ff; nxt_erren = erren_ff; nxt_prdata = prdata_ff;
    if (wr) begin
      case (apb_i.paddr)
        A_CTRL:  nxt_ctrl = apb_i.pwdata & 32'h0000_03ff;
        A_IVAL:  nxt_ival = (apb_i.pwdata == 32'h0) ? 32'h1 : apb_i.pwdata;
        A_SLIM:  nxt_slim = {16'h0, apb_i.pwdata[15:0]};
        A_PLO:   nxt_plo = apb_i.pwdata;
        A_PHI:   nxt_phi = apb_i.pwdata;
        A_PREF:  nxt_pref = apb_i.pwdata;
        A_HYST:  nxt_hyst = {26'h0, apb_i.pwdata[5:0]};
        A_TLIM:  nxt_tlim = {19'h0, apb_i.pwdata[12:0]};
        A_TOL:   nxt_tol = apb_i.pwdata;
        A_IMASK: nxt_imask = {22'h0, apb_i.pwdata[N_IRQ-1:0]};
        A_ERREN: nxt_erren = {23'h0, apb_i.pwdata[N_ERR-1:0]};
        default: ;
      endcase
    end
    // set wins over a simultaneous write-one clear
    nxt_istat = istat_ff | irq_ev;
    if (wr && apb_i.paddr == A_ISTAT)
      nxt_istat = (istat_ff & ~apb_i.pwdata[N_IRQ-1:0]) | irq_ev;
    if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
      case (apb_i.paddr)
        A_CTRL:  nxt_prdata = ctrl_ff;
        A_IVAL:  nxt_prdata = ival_ff;
        A_SLIM:  nxt_prdata = slim_ff;
        A_PLO:   nxt_prdata = plo_ff;
        A_PHI:   nxt_prdata = phi_ff;
        A_PREF:  nxt_prdata = pref_ff;
        A_HYST:  nxt_prdata = hyst_ff;
        A_TLIM:  nxt_prdata = tlim_ff;
        A_TOL:   nxt_prdata = tol_ff;
        A_STAT:  nxt_prdata = {19'h0, err_ff, 1'b0, reset_req_o, restart_req_o, release_o};
        A_POS:   nxt_prdata = 32'(pos_ff[0]);
        A_SPD:   nxt_prdata = 32'(spd_ff[0]);
        A_ISTAT: nxt_prdata = {22'h0, istat_ff};
        A_IMASK: nxt_prdata = imask_ff;
        A_ERREN: nxt_prdata = erren_ff;
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST; ival_ff <= 32'(IVAL_DEF); slim_ff <= 32'h0; plo_ff <= 32'h0;
      phi_ff <= 32'h0; pref_ff <= 32'h0; hyst_ff <= 32'h0; tlim_ff <= 32'(TLIM_S_DEF);
      tol_ff <= 32'h0; imask_ff <= 32'h0; erren_ff <= 32'h0; prdata_ff <= 32'h0;
      istat_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl; ival_ff <= nxt_ival; slim_ff <= nxt_slim; plo_ff <= nxt_plo;
      phi_ff <= nxt_phi; pref_ff <= nxt_pref; hyst_ff <= nxt_hyst; tlim_ff <= nxt_tlim;
      tol_ff <= nxt_tol; imask_ff <= nxt_imask; erren_ff <= nxt_erren; prdata_ff <= nxt_prdata;
      istat_ff <= nxt_istat;
    end
  end
  assign irq_o = |(istat_ff & imask_ff[N_IRQ-1:0]);

  // timebases: measuring interval and millisecond tick
  logic [31:0] iv_ff, nxt_iv;
  logic [15:0] ms_ff, nxt_ms;
  logic        tick, ms_tick;
  assign tick    = (iv_ff >= ival_ff - 32'h1);
  assign ms_tick = (ms_ff == 16'(CYC_MS - 1));
  assign nxt_iv  = tick ? 32'h0 : iv_ff + 32'h1;
  assign nxt_ms  = ms_tick ? 16'h0 : ms_ff + 16'h1;

  // edge detectors on the control inputs, one sample per cycle
  logic rf_ff, rs_ff, rp_ff, ref_fall, restart_done, reset_done;
  assign ref_fall     = ref_en & rf_ff & ~ctl_i.refer;
  assign restart_done = rs_ff & ~ctl_i.restart;
  assign reset_done   = rp_ff & ~ctl_i.reset;

  // per-sensor quadrature decode, counting, position and fault detection
  for (genvar i = 0; i < 2; i++) begin : g_sens
    ssm_quad_t          s, prv_ff;
    logic               da, db, la_ff, lb_ff, fwd;
    logic [2:0]         ca_ff, cb_ff, nxt_ca, nxt_cb;
    logic signed [31:0] step, nxt_cnt, nxt_pos, nxt_spd;
    assign s   = (i == 0 || two) ? sens_i[i] : '0;
    assign da  = s.a ^ prv_ff.a;
    assign db  = s.b ^ prv_ff.b;
    assign fwd = da ? (s.a != s.b) : (s.a == s.b);
    always_comb begin
      step = 32'sh0;
      if (da ^ db)
        step = fwd ? 32'sh1 : -32'sh1;
      nxt_cnt = tick ? 32'sh0 : cnt_ff[i] + step;
      nxt_spd = tick ? cnt_ff[i] + step : spd_ff[i];
      nxt_pos = ref_fall ? $signed(pref_ff) : pos_ff[i] + step;
      nxt_ca = db ? 3'h0 : (da && ca_ff != 3'(STUCK_N)) ? ca_ff + 3'h1 : ca_ff;
      nxt_cb = da ? 3'h0 : (db && cb_ff != 3'(STUCK_N)) ? cb_ff + 3'h1 : cb_ff;
    end
    assign ph_ev[i] = da & db;
    assign co_ev[i] = (da & la_ff) | (db & lb_ff);
    assign st_ev[i] = (ca_ff == 3'(STUCK_N)) | (cb_ff == 3'(STUCK_N));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        prv_ff <= '0; la_ff <= 1'b0; lb_ff <= 1'b0; ca_ff <= 3'h0; cb_ff <= 3'h0;
        cnt_ff[i] <= 32'sh0; spd_ff[i] <= 32'sh0; pos_ff[i] <= 32'sh0;
      end else begin
        prv_ff <= s; la_ff <= da; lb_ff <= db; ca_ff <= nxt_ca; cb_ff <= nxt_cb;
        cnt_ff[i] <= nxt_cnt; spd_ff[i] <= nxt_spd; pos_ff[i] <= nxt_pos;
      end
    end
  end

  // standstill evaluation with hysteresis on switch-on
  logic [31:0] lim, mag, hh, hl, span;
  logic signed [31:0] lo_e, hi_e;
  logic        spd_ok, pos_ok, granted, sdev, pdev, dev, dev_out, mon_ok;
  logic [15:0] dv_ff, nxt_dv;
  assign granted = (st_ff == SSM_GRANT);
  assign mag     = absv(spd_ff[0]);
  assign lim     = granted ? slim_ff : slim_ff - hyst_amt(slim_ff, hyst_ff[5:0]);
  assign spd_ok  = dir_on ? (mag < lim) : (!spd_ff[0][31] && mag < lim);
  assign hh      = granted ? 32'h0 : hyst_amt(absv($signed(phi_ff)), hyst_ff[5:0]);
  assign hl      = granted ? 32'h0 : hyst_amt(absv($signed(plo_ff)), hyst_ff[5:0]);
  assign hi_e    = $signed(phi_ff) - $signed(hh);
  assign lo_e    = $signed(plo_ff) + $signed(hl);
  assign pos_ok  = (pos_ff[0] >= lo_e) && (pos_ff[0] <= hi_e);
  assign span    = phi_ff - plo_ff;
  assign sdev    = cmp_on & spd_chk & (absv(spd_ff[0] - spd_ff[1]) > {16'h0, tol_ff[15:0]});
  assign pdev    = cmp_on & pos_chk & (absv(pos_ff[0] - pos_ff[1]) > {16'h0, tol_ff[15:0]});
  assign dev     = sdev | pdev;
  assign dev_out = dev & (dv_ff >= tol_ff[31:16]);
  assign nxt_dv  = !dev ? 16'h0 : (ms_tick && !dev_out) ? dv_ff + 16'h1 : dv_ff;

  always_comb begin
    live           = '0;
    live[E_CUTOFF] = |co_ev;
    live[E_PHASE]  = |ph_ev;
    live[E_STUCK]  = |st_ev;
    live[E_DISC]   = cmp_on & (spd_ff[0][31] ^ spd_ff[1][31]) & (spd_ff[0] != 0) & (spd_ff[1] != 0);
    live[E_SLIM]   = spd_chk & (mag > {slim_ff[30:0], 1'b0});
    live[E_SDIFF]  = sdev & dev_out;
    live[E_PRNG]   = pos_chk & ((pos_ff[0] < $signed(plo_ff - span)) | (pos_ff[0] > $signed(phi_ff + span)));
    live[E_PDIFF]  = pdev & dev_out;
    live[E_GEN]    = |live[N_ERR-1:1];
  end
  assign mon_ok = (~pos_chk | pos_ok) & (~spd_chk | spd_ok) & ~|live;

  // time limit on mute and bypass
  // an input held past the limit stays expired until dropped, so no silent re-arm
  logic [22:0] ov_ff, nxt_ov, tl_ms;
  logic        ovr_raw, expired, mute_act, byp_act;
  assign tl_ms    = 23'(tlim_ff[12:0]) * 23'(MS_PER_S);
  assign ovr_raw  = (mute_en & ctl_i.mute) | (byp_en & ctl_i.bypass);
  assign expired  = tlim_on & (ov_ff >= tl_ms);
  assign nxt_ov   = !ovr_raw ? 23'h0 : (ms_tick && !expired) ? ov_ff + 23'h1 : ov_ff;
  assign mute_act = mute_en & ctl_i.mute & ~expired;
  assign byp_act  = byp_en & ctl_i.bypass & ~expired;

  // release state machine
  always_comb begin
    nxt_st  = st_ff;
    nxt_err = err_ff | live;
    case (st_ff)
      SSM_IDLE:     if (mon_ok) nxt_st = manual ? SSM_WAIT_ACK : SSM_GRANT;
      SSM_WAIT_ACK: if (!mon_ok) nxt_st = SSM_IDLE;
                    else if (restart_done) nxt_st = SSM_GRANT;
      SSM_GRANT:    if (!mon_ok) nxt_st = SSM_IDLE;
      SSM_FAULT:    if (reset_done && !(|live)) begin
                      nxt_st  = SSM_IDLE;
                      nxt_err = '0;
                    end
      default:      nxt_st = SSM_IDLE;
    endcase
    if (|live)
      nxt_st = SSM_FAULT;
    nxt_rel = (nxt_st == SSM_GRANT) | (mute_act & rel_ff) | byp_act;
    irq_ev  = {rel_ff ^ nxt_rel, live & ~err_ff};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= SSM_IDLE; rel_ff <= 1'b0; err_ff <= '0; iv_ff <= 32'h0; ms_ff <= 16'h0;
      ov_ff <= 23'h0; dv_ff <= 16'h0; rf_ff <= 1'b0; rs_ff <= 1'b0; rp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; rel_ff <= nxt_rel; err_ff <= nxt_err; iv_ff <= nxt_iv; ms_ff <= nxt_ms;
      ov_ff <= nxt_ov; dv_ff <= nxt_dv; rf_ff <= ctl_i.refer; rs_ff <= ctl_i.restart;
      rp_ff <= ctl_i.reset;
    end
  end
  assign release_o     = rel_ff;
  assign restart_req_o = (st_ff == SSM_WAIT_ACK);
  assign reset_req_o   = (st_ff == SSM_FAULT);
  assign err_o         = err_ff & erren_ff[N_ERR-1:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ref_load: assert property (ref_fall |=> pos_ff[0] == $signed($past(pref_ff))) else $error("ref load");
  a_auto_grant: assert property ((st_ff == SSM_IDLE) && !manual && mon_ok |=> release_o) else $error("auto");
  a_restart_hold: assert property ((st_ff == SSM_WAIT_ACK) && !restart_done && mon_ok
    |=> restart_req_o && !(st_ff == SSM_GRANT)) else $error("restart");
  a_restart_req: assert property ((st_ff == SSM_IDLE) && manual && mon_ok |=> restart_req_o)
    else $error("restart req");
  a_mute_keep: assert property (release_o && mute_act |=> release_o) else $error("mute");
  a_bypass_force: assert property (byp_act |=> release_o) else $error("bypass");
  a_fault_reset: assert property ((|live) |=> reset_req_o && (!release_o || $past(byp_act || mute_act)))
    else $error("fault");
  a_release_cause: assert property (release_o |-> $past(mon_ok || byp_act || mute_act)) else $error("rel");
  a_tlim_end: assert property (expired |-> !mute_act && !byp_act) else $error("time limit");
  a_interval: assert property (tick |=> iv_ff == 32'h0 ##1 iv_ff == 32'h1 || tick) else $error("ival");
  a_dir_off: assert property (!dir_on && spd_ff[0][31] |-> !spd_ok) else $error("direction");
  a_hyst_on: assert property (!granted && spd_chk && mag >= slim_ff - hyst_amt(slim_ff, hyst_ff[5:0])
    |=> !granted) else $error("hysteresis");
  a_byp_off: assert property (!byp_en && !mute_en |-> !ovr_raw) else $error("enable");
endmodule

// ---- verification/ssm_motion_model.sv ----
// behavioural quadrature motion sensor driven step by step from the bench
`timescale 1ns/1ns
module ssm_motion_model import ssm_pkg::*; (
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic fwd_i,
  input  wire logic bad_i,
  output ssm_quad_t quad_o
);
  logic [1:0] pos_ff = 2'h0;
  logic [1:0] nxt_pos;

  // one track edge per step, so a step every cycle never repeats a track
  always_comb begin
    nxt_pos = pos_ff;
    if (bad_i) begin
      nxt_pos = pos_ff ^ 2'h2; // both tracks flip: deliberate phase fault
    end else if (step_i) begin
      nxt_pos = fwd_i ? pos_ff + 2'h1 : pos_ff - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    pos_ff <= nxt_pos;
  end

  // a leads b when moving forward
  assign quad_o = '{a: pos_ff[0] ^ pos_ff[1], b: pos_ff[1]};
endmodule

// ---- verification/tb.sv ----
// self-checking bench: apb register access, motion stimulus and release control checks
`timescale 1ns/1ns
module tb import ssm_pkg::*;;
  localparam int LIMIT = 20000;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  ssm_apb_req_t apb_r = '0;
  ssm_ctl_t     ctl   = '0;
  logic         step  = 1'b0;
  logic         fwd   = 1'b1;
  logic         bad   = 1'b0;
  ssm_quad_t    quad;
  ssm_quad_t    q1    = '0;
  logic         frz   = 1'b0;
  logic [31:0]  prdata_o;
  logic         pready_o, pslverr_o, release_o, restart_req_o, reset_req_o, irq_o;
  logic [8:0]   err_o;
  logic [3:0]   obs;
  logic [31:0]  rdat;
  logic         rerr;
  int           err_count = 0;
  int           check_count = 0;
  int           cyc = 0;

  always #25 clk_i = ~clk_i;
  assign obs = {irq_o, reset_req_o, restart_req_o, release_o};

  ssm_standstill_monitor #(.CYC_MS(4), .IVAL_DEF(16), .HAS_S2(1'b1), .STUCK_N(4)) u_ssm_standstill_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_r), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .sens_i({q1, quad}), .ctl_i(ctl), .release_o(release_o),
    .restart_req_o(restart_req_o), .reset_req_o(reset_req_o), .err_o(err_o), .irq_o(irq_o));

  ssm_motion_model u_ssm_motion_model (.clk_i(clk_i), .step_i(step), .fwd_i(fwd), .bad_i(bad), .quad_o(quad));

  // sensor 1 trails sensor 0 by a cycle; frz parks it to open a deviation
  always @(posedge clk_i) begin
    if (!frz)
      q1 <= quad;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    apb_r <= {1'b1, 1'b0, w, a, wd};
    @(posedge clk_i);
    apb_r.penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rdat = prdata_o;
    rerr = pslverr_o;
    apb_r <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // observe on the falling edge so registered outputs have settled
  task automatic wait_on(input int s, input logic v, input int lim);
    int i;
    i = 0;
    @(negedge clk_i);
    while (obs[s] !== v && i < lim) begin
      @(negedge clk_i);
      i++;
    end
    chk({31'h0, obs[s]}, {31'h0, v});
  endtask

  task automatic move(input int n, input int gap, input logic dir);
    @(posedge clk_i);
    fwd <= dir;
    for (int i = 0; i < n * gap; i++) begin
      step <= (i % gap == 0);
      @(posedge clk_i);
    end
    step <= 1'b0;
  endtask

  // low-high-low pulse on one control bit: 4 refer, 3 restart, 2 reset
  task automatic pulse(input int f);
    @(posedge clk_i);
    ctl[f] <= 1'b1;
    repeat (2) @(posedge clk_i);
    ctl[f] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic done(input string name);
    $display("test %s finished, checks=%0d", name, check_count);
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(A_CTRL, 32'h0000_0082);
    rdc(A_TLIM, 32'h0000_0001);
    rdc(A_IVAL, 32'h0000_0010);
    rdc(8'h3c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    done("defaults");
    wr(A_ERREN, 32'h0000_01ff);
    wr(A_SLIM, 32'h0000_0005);
    wait_on(0, 1'b1, 100);
    wait_on(3, 1'b0, 0);
    wr(A_IMASK, 32'h0000_0200);
    wait_on(3, 1'b1, 3);
    wr(A_ISTAT, 32'h0000_0200);
    wait_on(3, 1'b0, 3);
    done("auto release and interrupt");
    move(24, 2, 1'b1);
    wait_on(0, 1'b0, 0);
    chk({23'h0, err_o}, 32'h0);
    move(8, 8, 1'b0);
    wait_on(0, 1'b0, 0);
    wr(A_CTRL, 32'h0000_0182);
    move(8, 8, 1'b0);
    wait_on(0, 1'b1, 0);
    done("speed limit and direction");
    wr(A_CTRL, 32'h0000_008a);
    move(24, 2, 1'b1);
    wait_on(0, 1'b0, 0);
    wait_on(1, 1'b1, 60);
    wait_on(0, 1'b0, 0);
    pulse(3);
    wait_on(0, 1'b1, 3);
    wait_on(1, 1'b0, 0);
    done("manual restart");
    wr(A_CTRL, 32'h0000_0082);
    move(32, 1, 1'b1);
    wait_on(2, 1'b1, 40);
    wait_on(0, 1'b0, 0);
    chk({31'h0, err_o[E_SLIM]}, 32'h1);
    apb(1'b0, A_ISTAT, 32'h0);
    chk(rdat & 32'h20, 32'h20);
    repeat (40) @(posedge clk_i);
    pulse(2);
    wait_on(2, 1'b0, 3);
    chk({23'h0, err_o}, 32'h0);
    @(posedge clk_i);
    bad <= 1'b1;
    @(posedge clk_i);
    bad <= 1'b0;
    wait_on(2, 1'b1, 5);
    chk({31'h0, err_o[E_PHASE]}, 32'h1);
    pulse(2);
    wait_on(2, 1'b0, 3);
    done("faults and reset");
    wr(A_PLO, 32'd1000);
    wr(A_PHI, 32'd2000);
    wr(A_CTRL, 32'h0000_0081);
    wait_on(0, 1'b0, 10);
    @(posedge clk_i);
    ctl.bypass <= 1'b1;
    repeat (10) @(posedge clk_i);
    wait_on(0, 1'b0, 0);
    wr(A_CTRL, 32'h0000_00c1);
    wait_on(0, 1'b1, 3);
    repeat (3850) @(posedge clk_i);
    wait_on(0, 1'b1, 0);
    wait_on(0, 1'b0, 200);
    @(posedge clk_i);
    ctl.bypass <= 1'b0;
    done("bypass and time limit");
    wr(A_PREF, 32'd1500);
    wr(A_CTRL, 32'h0000_0091);
    pulse(4);
    rdc(A_POS, 32'd1500);
    wait_on(0, 1'b1, 20);
    wr(A_CTRL, 32'h0000_00b1);
    ctl.mute <= 1'b1;
    wr(A_PREF, 32'd0);
    pulse(4);
    repeat (10) @(posedge clk_i);
    wait_on(0, 1'b1, 0);
    @(posedge clk_i);
    ctl.mute <= 1'b0;
    wait_on(0, 1'b0, 5);
    done("reference and mute");
    wr(A_HYST, 32'd10);
    wr(A_PREF, 32'd1050);
    pulse(4);
    repeat (4) @(posedge clk_i);
    wait_on(0, 1'b0, 0);
    wr(A_HYST, 32'd0);
    wait_on(0, 1'b1, 5);
    wr(A_HYST, 32'd10);
    repeat (4) @(posedge clk_i);
    wait_on(0, 1'b1, 0);
    done("hysteresis");
    move(2, 4, 1'b1);
    wr(A_TOL, 32'h0008_0004);
    wr(A_CTRL, 32'h0000_02b5);
    frz <= 1'b1;
    move(8, 4, 1'b1);
    wait_on(0, 1'b1, 0);
    wait_on(2, 1'b1, 40);
    chk({31'h0, err_o[E_PDIFF]}, 32'h1);
    wr(A_ERREN, 32'h0000_00ff);
    @(negedge clk_i);
    chk({31'h0, err_o[E_PDIFF]}, 32'h0);
    done("two inputs and comparison");
    wrap_up();
  end
endmodule
